// *** core/mlm_core.sv ***
// Motor settings, motion options, current limit and move profile
`timescale 1ns/1ps
`include "mlm_defs.svh"
module mlm_core #(
	parameter logic [15:0] TICK_CYCLES = 16'(`MLM_TICK_CYCLES)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register bus
	input wire mlm_pkg::mlm_apb_req_t apb_req,
	output mlm_pkg::mlm_apb_rsp_t apb_rsp,
	// Motor side pins
	input wire logic [15:0] measured_current,
	input wire logic feedback_pulse,
	input wire logic feedback_up,
	// Same-clock speed capability
	input wire logic [31:0] max_achievable_speed,
	// Drive outputs
	output logic step_pulse,
	output logic drive_dir,
	output logic [15:0] current_cmd,
	output logic overcurrent
);
	import mlm_pkg::*;

	mlm_state_t s_r;
	mlm_state_t s_nxt;

	function automatic logic [31:0] mlm_clamp(input logic [31:0] v);
		mlm_clamp = (v > `MLM_SPEED_MAX) ? `MLM_SPEED_MAX : v;
	endfunction : mlm_clamp

	function automatic logic [31:0] mlm_usteps(input logic [31:0] whole,
		input logic [7:0] frac, input logic [3:0] div);
		logic [3:0] d;
		logic [7:0] fm;
		d = (div > `MLM_DIV_MAX) ? `MLM_DIV_MAX : div;
		fm = frac & 8'((9'h001 << d) - 9'h001);
		mlm_usteps = (whole << d) + {24'h0, fm};
	endfunction : mlm_usteps

	function automatic logic mlm_mapped(input logic [7:0] a);
		mlm_mapped = (a == `MLM_ADDR_CURRENT) || (a == `MLM_ADDR_SPEED) ||
			(a == `MLM_ADDR_FRACTION) || (a == `MLM_ADDR_OPTIONS) ||
			(a == `MLM_ADDR_CTRL) || (a == `MLM_ADDR_ACCEL) ||
			(a == `MLM_ADDR_TARGET) || (a == `MLM_ADDR_POSITION) ||
			(a == `MLM_ADDR_STATUS);
	endfunction : mlm_mapped

	logic access;
	logic do_write;
	logic tick;
	logic fb_edge;
	logic reached;
	logic near_end;
	logic [31:0] base;
	logic [31:0] cruise;
	logic [31:0] slow;
	logic [31:0] remain;
	logic [31:0] ramped;
	logic [23:0] scaled;
	logic [16:0] peak;
	logic [31:0] rd;
	logic [15:0] opt;

	mlm_rate_gen u_rate (
		.clock(clock),
		.sys_rst(sys_rst),
		.run(s_r.phase != MLM_IDLE && !s_r.overcurrent),
		.speed(s_r.speed),
		.step_pulse(step_pulse)
	);

	always_comb begin
		s_nxt = s_r;
		opt = s_r.motion_option_mask;
		access = apb_req.psel && apb_req.penable;
		do_write = access && s_r.rsp.pready && apb_req.pwrite &&
			mlm_mapped(apb_req.paddr);
		tick = (s_r.tick_cnt == TICK_CYCLES - 16'h0001);
		fb_edge = s_r.fb_pulse_s2 && !s_r.fb_pulse_s3;

		// Pin synchronisers
		s_nxt.fb_pulse_s1 = feedback_pulse;
		s_nxt.fb_pulse_s2 = s_r.fb_pulse_s1;
		s_nxt.fb_pulse_s3 = s_r.fb_pulse_s2;
		s_nxt.fb_up_s1 = feedback_up;
		s_nxt.fb_up_s2 = s_r.fb_up_s1;
		s_nxt.meas_s1 = measured_current;
		s_nxt.meas_s2 = s_r.meas_s1;

		s_nxt.tick_cnt = tick ? 16'h0000 : s_r.tick_cnt + 16'h0001;

		// Feedback position: counts up on increasing feedback
		if (fb_edge) begin
			s_nxt.position = s_r.fb_up_s2 ? s_r.position + 32'h1 :
				s_r.position - 32'h1;
		end

		// Peak current target from rated value
		scaled = {8'h00, s_r.rated_current_value} * `MLM_RMS_TO_PEAK;
		peak = scaled[23:7];
		if (opt[`MLM_OPT_RMS]) begin
			s_nxt.current_cmd = peak[16] ? 16'hffff : peak[15:0];
		end else begin
			s_nxt.current_cmd = s_r.rated_current_value;
		end
		s_nxt.overcurrent = s_r.current_limit_enable &&
			(s_r.meas_s2 >= s_r.current_cmd);

		// Cruise speed in microsteps per second
		if (opt[`MLM_OPT_MAX_SPEED]) begin
			base = mlm_clamp(max_achievable_speed);
			cruise = mlm_usteps(base, 8'h00, s_r.step_division_setting);
		end else begin
			base = mlm_clamp(s_r.nominal_speed_whole);
			cruise = mlm_usteps(base, s_r.nominal_speed_fraction,
				s_r.step_division_setting);
		end
		if (!s_r.speed_limit_enable) begin
			cruise = mlm_usteps(mlm_clamp(max_achievable_speed), 8'h00,
				s_r.step_division_setting);
		end
		slow = mlm_usteps(`MLM_SLOW_SPEED, 8'h00, s_r.step_division_setting);
		if (slow > cruise) begin
			slow = cruise;
		end

		// Move progress
		reached = s_r.dir_up ?
			($signed(s_r.position) >= $signed(s_r.target)) :
			($signed(s_r.position) <= $signed(s_r.target));
		remain = s_r.dir_up ? s_r.target - s_r.position :
			s_r.position - s_r.target;
		near_end = opt[`MLM_OPT_BACKLASH] &&
			(s_r.target == s_r.final_target) &&
			($signed(remain) <= $signed(`MLM_APPROACH_LEN));
		ramped = s_r.speed + {16'h0, s_r.accel};
		if (ramped > cruise || ramped < s_r.speed) begin
			ramped = cruise;
		end

		unique case (s_r.phase)
			MLM_IDLE: begin
				s_nxt.speed = 32'h0;
			end
			MLM_RUN: begin
				if (reached && s_r.target != s_r.final_target) begin
					s_nxt.target = s_r.final_target;
					s_nxt.dir_up = 1'b1;
					s_nxt.phase = MLM_APPROACH;
					s_nxt.speed = slow;
				end else if (reached) begin
					s_nxt.phase = MLM_IDLE;
					s_nxt.speed = 32'h0;
				end else if (near_end) begin
					s_nxt.phase = MLM_APPROACH;
					s_nxt.speed = slow;
				end else if (!opt[`MLM_OPT_RAMP]) begin
					s_nxt.speed = cruise;
				end else if (tick) begin
					s_nxt.speed = ramped;
				end
			end
			MLM_APPROACH: begin
				s_nxt.speed = slow;
				if (reached) begin
					s_nxt.phase = MLM_IDLE;
					s_nxt.speed = 32'h0;
				end
			end
		endcase

		// Drive pin: direction after optional inversion
		s_nxt.drive_dir = s_nxt.dir_up ^ opt[`MLM_OPT_INVERT];

		// Register read data
		rd = 32'h0;
		unique case (apb_req.paddr)
			`MLM_ADDR_CURRENT: rd = {16'h0, s_r.rated_current_value};
			`MLM_ADDR_SPEED: rd = s_r.nominal_speed_whole;
			`MLM_ADDR_FRACTION: rd = {24'h0, s_r.nominal_speed_fraction};
			`MLM_ADDR_OPTIONS: rd = {16'h0, opt};
			`MLM_ADDR_CTRL: rd = {24'h0, s_r.step_division_setting, 2'b00,
				s_r.speed_limit_enable, s_r.current_limit_enable};
			`MLM_ADDR_ACCEL: rd = {16'h0, s_r.accel};
			`MLM_ADDR_TARGET: rd = s_r.final_target;
			`MLM_ADDR_POSITION: rd = s_r.position;
			`MLM_ADDR_STATUS: rd = {28'h0, s_r.phase, s_r.overcurrent,
				s_r.phase != MLM_IDLE};
			default: rd = 32'h0;
		endcase

		// APB answer one cycle into the access phase
		s_nxt.rsp.pready = access && !s_r.rsp.pready;
		if (access && !s_r.rsp.pready) begin
			s_nxt.rsp.prdata = apb_req.pwrite ? 32'h0 : rd;
			s_nxt.rsp.pslverr = !mlm_mapped(apb_req.paddr);
		end else begin
			s_nxt.rsp.prdata = 32'h0;
			s_nxt.rsp.pslverr = 1'b0;
		end

		if (do_write) begin
			unique case (apb_req.paddr)
				`MLM_ADDR_CURRENT: begin
					s_nxt.rated_current_value = apb_req.pwdata[15:0];
				end
				`MLM_ADDR_SPEED: begin
					s_nxt.nominal_speed_whole = apb_req.pwdata;
				end
				`MLM_ADDR_FRACTION: begin
					s_nxt.nominal_speed_fraction = apb_req.pwdata[7:0];
				end
				`MLM_ADDR_OPTIONS: begin
					s_nxt.motion_option_mask = apb_req.pwdata[15:0];
				end
				`MLM_ADDR_CTRL: begin
					s_nxt.current_limit_enable =
						apb_req.pwdata[`MLM_CTRL_CUR_LIM];
					s_nxt.speed_limit_enable = apb_req.pwdata[`MLM_CTRL_SPD_LIM];
					s_nxt.step_division_setting =
						apb_req.pwdata[`MLM_CTRL_DIV_LO +: 4];
				end
				`MLM_ADDR_ACCEL: begin
					s_nxt.accel = apb_req.pwdata[15:0];
				end
				`MLM_ADDR_TARGET: begin
					if (s_r.phase == MLM_IDLE) begin
						s_nxt.final_target = apb_req.pwdata;
						s_nxt.target = apb_req.pwdata;
						if (opt[`MLM_OPT_BACKLASH] && $signed(apb_req.pwdata) <
							$signed(s_r.position)) begin
							s_nxt.target = apb_req.pwdata - `MLM_BACKLASH_LEN;
						end
						s_nxt.dir_up = $signed(s_nxt.target) > $signed(s_r.position);
						s_nxt.drive_dir = s_nxt.dir_up ^ opt[`MLM_OPT_INVERT];
						s_nxt.phase = MLM_RUN;
						s_nxt.speed = opt[`MLM_OPT_RAMP] ? slow : cruise;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.rated_current_value <= `MLM_RST_CURRENT;
			s_r.nominal_speed_whole <= `MLM_RST_SPEED;
			s_r.nominal_speed_fraction <= `MLM_RST_FRACTION;
			s_r.motion_option_mask <= `MLM_RST_OPTIONS;
			s_r.accel <= `MLM_RST_ACCEL;
			s_r.phase <= MLM_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp = s_r.rsp;
	assign drive_dir = s_r.drive_dir;
	assign current_cmd = s_r.current_cmd;
	assign overcurrent = s_r.overcurrent;

endmodule : mlm_core

// *** core/mlm_defs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef MLM_DEFS_SVH
`define MLM_DEFS_SVH

`define MLM_ADDR_CURRENT 8'h00
`define MLM_ADDR_SPEED 8'h04
`define MLM_ADDR_FRACTION 8'h08
`define MLM_ADDR_OPTIONS 8'h0c
`define MLM_ADDR_CTRL 8'h10
`define MLM_ADDR_ACCEL 8'h14
`define MLM_ADDR_TARGET 8'h18
`define MLM_ADDR_POSITION 8'h1c
`define MLM_ADDR_STATUS 8'h20

`define MLM_OPT_INVERT 0
`define MLM_OPT_RMS 1
`define MLM_OPT_MAX_SPEED 2
`define MLM_OPT_BACKLASH 3
`define MLM_OPT_RAMP 4

`define MLM_CTRL_CUR_LIM 0
`define MLM_CTRL_SPD_LIM 1
`define MLM_CTRL_DIV_LO 4

`define MLM_RST_CURRENT 16'h0000
`define MLM_RST_SPEED 32'h0000_0000
`define MLM_RST_FRACTION 8'h00
`define MLM_RST_OPTIONS 16'h0000
`define MLM_RST_ACCEL 16'h0000

`define MLM_SPEED_MAX 32'h0001_86a0
`define MLM_DIV_MAX 4'h8
`define MLM_RMS_TO_PEAK 24'h0000b5
`define MLM_SLOW_SPEED 32'h0000_0064
`define MLM_BACKLASH_LEN 32'h0000_0100
`define MLM_APPROACH_LEN 32'h0000_0080

`define MLM_CLK_HZ 32'h02fa_f080
`define MLM_CLK_PERIOD_NS 20
`define MLM_TICK_NS 1000000
`define MLM_TICK_CYCLES (`MLM_TICK_NS / `MLM_CLK_PERIOD_NS)

`endif

// *** core/mlm_pkg.sv ***
// Types shared by the motor limit and motion option block
package mlm_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} mlm_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mlm_apb_rsp_t;

	typedef enum logic [1:0] {
		MLM_IDLE,
		MLM_RUN,
		MLM_APPROACH
	} mlm_phase_t;

	typedef struct packed {
		mlm_apb_rsp_t rsp;
		logic [15:0] rated_current_value;
		logic [31:0] nominal_speed_whole;
		logic [7:0] nominal_speed_fraction;
		logic [15:0] motion_option_mask;
		logic current_limit_enable;
		logic speed_limit_enable;
		logic [3:0] step_division_setting;
		logic [15:0] accel;
		logic [31:0] target;
		logic [31:0] final_target;
		logic [31:0] position;
		logic [31:0] speed;
		logic [15:0] tick_cnt;
		mlm_phase_t phase;
		logic dir_up;
		logic drive_dir;
		logic [15:0] current_cmd;
		logic overcurrent;
		logic fb_pulse_s1;
		logic fb_pulse_s2;
		logic fb_pulse_s3;
		logic fb_up_s1;
		logic fb_up_s2;
		logic [15:0] meas_s1;
		logic [15:0] meas_s2;
	} mlm_state_t;

	typedef struct packed {
		logic [31:0] acc;
		logic pulse;
	} mlm_rate_t;

endpackage : mlm_pkg

// *** core/mlm_rate_gen.sv ***
// Step rate generator: phase accumulator in microsteps per second
`timescale 1ns/1ps
`include "mlm_defs.svh"
module mlm_rate_gen (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Rate request
	input wire logic run,
	input wire logic [31:0] speed,
	// Step output
	output logic step_pulse
);
	import mlm_pkg::*;

	mlm_rate_t s_r;
	mlm_rate_t s_nxt;
	logic [31:0] sum;

	always_comb begin
		s_nxt = s_r;
		sum = s_r.acc + speed;
		s_nxt.pulse = 1'b0;
		if (!run) begin
			s_nxt.acc = 32'h0;
		end else if (sum >= `MLM_CLK_HZ) begin
			s_nxt.acc = sum - `MLM_CLK_HZ;
			s_nxt.pulse = 1'b1;
		end else begin
			s_nxt.acc = sum;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign step_pulse = s_r.pulse;

endmodule : mlm_rate_gen

// *** tb/mlm_monitor.sv ***
// Bus and drive output checks for the motor option block
`timescale 1ns/1ps
module mlm_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register bus
	input wire mlm_pkg::mlm_apb_req_t apb_req,
	input wire mlm_pkg::mlm_apb_rsp_t apb_rsp,
	// Motor side
	input wire logic [15:0] measured_current,
	input wire logic feedback_pulse,
	input wire logic feedback_up,
	input wire logic [31:0] max_achievable_speed,
	input wire logic step_pulse,
	input wire logic drive_dir,
	input wire logic [15:0] current_cmd,
	input wire logic overcurrent
);
	import mlm_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic acc;
	logic wr;
	assign acc = apb_req.psel && apb_req.penable;
	assign wr = acc && apb_req.pwrite && apb_rsp.pready;
	ack_after_access_a: assert property (
		acc && !apb_rsp.pready |=> apb_rsp.pready)
		else $error("no ready after access");
	ack_single_a: assert property (
		apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (
		apb_rsp.pready && (apb_req.paddr > 8'h20 ||
		apb_req.paddr[1:0] != 2'b00) |-> apb_rsp.pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (
		apb_rsp.pready && apb_req.paddr <= 8'h20 &&
		apb_req.paddr[1:0] == 2'b00 |-> !apb_rsp.pslverr)
		else $error("error on mapped address");
	idle_data_a: assert property (
		!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
		else $error("response outside ready");
	reset_clear_a: assert property (
		$fell(sys_rst) |-> current_cmd == 16'h0 && !drive_dir
		&& !overcurrent && !step_pulse)
		else $error("outputs not clear after reset");
	cmd_settle_a: assert property (
		!wr && !$past(wr) |=> $stable(current_cmd))
		else $error("current command moved without write");
	oc_halt_a: assert property (
		overcurrent [*2] |-> !step_pulse)
		else $error("step during overcurrent");
	step_single_a: assert property (
		step_pulse |=> !step_pulse)
		else $error("step pulse too long");
endmodule : mlm_monitor

// *** tb/mlm_motor_model.sv ***
// Motor and feedback sensor model
`timescale 1ns/1ps
module mlm_motor_model (
	// Clock
	input wire logic clock,
	// Drive from the block
	input wire logic step_pulse,
	input wire logic drive_dir,
	// Bench controls
	input wire logic wiring_flip,
	input wire logic [15:0] load_current,
	// Sensor outputs
	output logic feedback_pulse,
	output logic feedback_up,
	output logic [15:0] measured_current
);
	logic step_d;
	logic up;
	logic on;
	assign up = drive_dir ^ wiring_flip;
	assign on = step_pulse | step_d;
	// Direction line only valid during the count pulse
	always_ff @(posedge clock) begin
		step_d <= step_pulse;
		feedback_pulse <= on;
		feedback_up <= on ? up : ~up;
		measured_current <= load_current;
	end
endmodule : mlm_motor_model

// *** tb/tb.sv ***
// Testbench for the motor limit and option block
`timescale 1ns/1ps
`include "mlm_defs.svh"
module tb;
	import mlm_pkg::*;
	logic clock = 0;
	logic sys_rst = 1;
	mlm_apb_req_t req = '0;
	mlm_apb_rsp_t rsp;
	logic [15:0] cur;
	logic fbp;
	logic fbu;
	logic step_pulse;
	logic drive_dir;
	logic [15:0] current_cmd;
	logic overcurrent;
	logic flip = 0;
	logic [15:0] load = 0;
	logic [31:0] q;
	logic e;
	int failures = 0;
	int checked = 0;
	int n;
	always #10 clock = ~clock;
	mlm_core #(.TICK_CYCLES(16'd16)) DUT (.clock(clock),
		.sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
		.measured_current(cur), .feedback_pulse(fbp),
		.feedback_up(fbu), .max_achievable_speed(32'd100000),
		.step_pulse(step_pulse), .drive_dir(drive_dir),
		.current_cmd(current_cmd), .overcurrent(overcurrent));
	mlm_motor_model MOT (.clock(clock), .step_pulse(step_pulse),
		.drive_dir(drive_dir), .wiring_flip(flip),
		.load_current(load), .feedback_pulse(fbp),
		.feedback_up(fbu), .measured_current(cur));
	task automatic stop_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic err);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clock);
		req.penable <= 1'b1;
		@(posedge clock);
		while (rsp.pready !== 1'b1)
			@(posedge clock);
		r = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// Idle edge so the next call never reassigns the strobes at once
		@(posedge clock);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask : rd
	task automatic move(input logic [31:0] t, input logic dir,
		input logic slow);
		wr(`MLM_ADDR_TARGET, t);
		for (n = 0; n < 3000 && step_pulse !== 1'b1; n++)
			@(posedge clock);
		if (n < 3000)
			chk({31'h0, drive_dir}, {31'h0, dir});
		chk({31'h0, n > 800}, {31'h0, slow});
		load <= 16'h0;
		q = 1;
		for (int i = 0; i < 2000 && q[0]; i++)
			xfer(1'b0, `MLM_ADDR_STATUS, 32'h0, q, e);
		rd(`MLM_ADDR_POSITION, t);
		$display("test move to %0d done", t);
	endtask : move
	initial begin
		#1500000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (int a = 0; a <= 8'h20; a += 4)
			rd(8'(a), 32'h0);
		$display("test reset done");
		wr(`MLM_ADDR_CURRENT, 32'hffff_03e8);
		rd(`MLM_ADDR_CURRENT, 32'h03e8);
		wr(`MLM_ADDR_FRACTION, 32'h1ab);
		rd(`MLM_ADDR_FRACTION, 32'hab);
		wr(`MLM_ADDR_SPEED, 32'd100000);
		rd(`MLM_ADDR_SPEED, 32'd100000);
		for (int i = 0; i < 16; i++) begin
			wr(`MLM_ADDR_OPTIONS, 32'h1 << i);
			rd(`MLM_ADDR_OPTIONS, 32'h1 << i);
		end
		xfer(1'b0, 8'h24, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		$display("test registers done");
		wr(`MLM_ADDR_OPTIONS, 32'h0);
		repeat (2) @(posedge clock);
		chk({16'h0, current_cmd}, 32'd1000);
		wr(`MLM_ADDR_OPTIONS, 32'h2);
		repeat (2) @(posedge clock);
		chk({16'h0, current_cmd}, 32'd1414);
		wr(`MLM_ADDR_CURRENT, 32'hffff);
		repeat (2) @(posedge clock);
		chk({16'h0, current_cmd}, 32'hffff);
		$display("test current meaning done");
		wr(`MLM_ADDR_SPEED, 32'h1);
		wr(`MLM_ADDR_CTRL, 32'h2);
		wr(`MLM_ADDR_OPTIONS, 32'h4);
		move(32'h4, 1'b1, 1'b0);
		flip <= 1'b1;
		wr(`MLM_ADDR_OPTIONS, 32'h5);
		move(32'h8, 1'b0, 1'b0);
		flip <= 1'b0;
		wr(`MLM_ADDR_ACCEL, 32'd1000);
		wr(`MLM_ADDR_OPTIONS, 32'h14);
		move(32'hc, 1'b1, 1'b1);
		wr(`MLM_ADDR_CURRENT, 32'd1000);
		wr(`MLM_ADDR_OPTIONS, 32'h4);
		wr(`MLM_ADDR_CTRL, 32'h3);
		load <= 16'd2000;
		repeat (10) @(posedge clock);
		chk({31'h0, overcurrent}, 32'h1);
		move(32'h10, 1'b1, 1'b1);
		wr(`MLM_ADDR_SPEED, 32'd100);
		wr(`MLM_ADDR_CTRL, 32'h82);
		wr(`MLM_ADDR_OPTIONS, 32'h0);
		// 100 whole steps at 256 divisions plus fraction 0xab
		move(32'h11, 1'b1, 1'b1);
		chk(n, 32'd1941);
		wr(`MLM_ADDR_OPTIONS, 32'hc);
		move(32'h12, 1'b1, 1'b1);
		wr(`MLM_ADDR_TARGET, 32'h40);
		repeat (4) @(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(`MLM_ADDR_STATUS, 32'h0);
		rd(`MLM_ADDR_OPTIONS, 32'h0);
		rd(`MLM_ADDR_POSITION, 32'h0);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule : tb
bind mlm_core mlm_monitor MON (.clock(clock), .sys_rst(sys_rst),
	.apb_req(apb_req), .apb_rsp(apb_rsp),
	.measured_current(measured_current),
	.feedback_pulse(feedback_pulse), .feedback_up(feedback_up),
	.max_achievable_speed(max_achievable_speed),
	.step_pulse(step_pulse), .drive_dir(drive_dir),
	.current_cmd(current_cmd), .overcurrent(overcurrent));
